// ---- bench/light_window_and_emitter_drive_regs_test.sv ----
module light_window_and_emitter_drive_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [6:0] DEV = 7'h40;
	localparam logic [6:0] OLD = 7'h41;
	logic        refClk = 0;
	logic        rst = 1;
	logic        resultValid = 0;
	logic        useInfrared = 0;
	logic        proxActive = 0;
	logic [15:0] visRes = 0;
	logic [15:0] irRes = 0;
	logic [7:0]  rb;
	wire         sclIn, sdaDrv, sdaOut, sdaOe, windowEvent;
	wire         sdaOut2, sdaOe2;
	wire         sdaLine = sdaDrv & ~(sdaOe & ~sdaOut) & ~(sdaOe2 & ~sdaOut2);
	wire [15:0]  lowLim, upLim, lastRes, lowLim2, upLim2;
	wire [11:0]  emitLvl, emitLvl2;
	wire [2:0]   emitSink, emitSink2;
	int          errorCnt = 0;
	int          nTests = 0;
	int          cycles = 0;
	initial forever #50 refClk = ~refClk;
	lwd_regs #(.DEV_ADDR(DEV)) dut (.ref_clk(refClk), .rst(rst), .sclIn(sclIn),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .resultValid(resultValid),
		.useInfrared(useInfrared), .visibleResult(visRes), .infraredResult(irRes),
		.proxActive(proxActive), .ambientLowerLimit(lowLim), .ambientUpperLimit(upLim),
		.windowEvent(windowEvent), .lastResult(lastRes), .emitterLevel(emitLvl),
		.emitterSink(emitSink));
	// older sequencer, single emitter: compressed limits, no upper low byte
	lwd_regs #(.DEV_ADDR(OLD), .SEQ_REV(8'h02), .EMITTERS(1)) dutOld (.ref_clk(refClk),
		.rst(rst), .sclIn(sclIn), .sdaIn(sdaLine), .sdaOut(sdaOut2), .sdaOe(sdaOe2),
		.resultValid(resultValid), .useInfrared(useInfrared), .visibleResult(visRes),
		.infraredResult(irRes), .proxActive(proxActive), .ambientLowerLimit(lowLim2),
		.ambientUpperLimit(upLim2), .windowEvent(), .lastResult(), .emitterLevel(emitLvl2),
		.emitterSink(emitSink2));
	lwd_host host (.ref_clk(refClk), .sdaLine(sdaLine), .sclDrive(sclIn),
		.sdaDrive(sdaDrv));
	task automatic printVerdict();
		if (errorCnt == 0 && nTests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		nTests++;
		if (g !== e) begin
			errorCnt++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rdDevChk(input logic [6:0] dv, input logic [7:0] p, input logic [7:0] e);
		host.rd(dv, p, rb);
		chk($sformatf("dev %h reg %h", dv, p), {8'h00, e}, {8'h00, rb});
	endtask
	task automatic rdChk(input logic [7:0] p, input logic [7:0] e);
		rdDevChk(DEV, p, e);
	endtask
	// unselected result is the complement, so a wrong select shows in lastResult and flips the in-window outcomes
	task automatic sample(input logic ir, input logic [15:0] v, input logic ev);
		@(posedge refClk);
		#10;
		useInfrared = ir;
		visRes = ir ? ~v : v;
		irRes = ir ? v : ~v;
		resultValid = 1'b1;
		@(posedge refClk);
		#10;
		resultValid = 1'b0;
		chk("windowEvent", {15'h0, ev}, {15'h0, windowEvent});
		chk("lastResult", v, lastRes);
	endtask
	always @(posedge refClk) begin
		cycles++;
		if (cycles == 30000) begin
			errorCnt++;
			printVerdict();
		end
	end
	initial begin
		repeat (3) @(posedge refClk);
		#10 rst = 0;
		repeat (2) @(posedge refClk);
		for (int k = 12; k <= 16; k++) rdChk(8'(k), 8'h00);
		host.wr(DEV, 8'h0b, 2, 16'h0180);
		host.wr(DEV, 8'h0d, 2, 16'h0240);
		chk("lower", 16'h0180, lowLim);
		chk("upper", 16'h0240, upLim);
		rdChk(8'h0c, 8'h01);
		rdChk(8'h0d, 8'h40);
		rdChk(8'h0e, 8'h02);
		sample(1'b0, 16'h017f, 1'b1);
		sample(1'b0, 16'h0180, 1'b0);
		sample(1'b0, 16'h0240, 1'b0);
		sample(1'b1, 16'h0241, 1'b1);
		sample(1'b1, 16'h0200, 1'b0);
		host.wr(DEV, 8'h0f, 2, 16'hf01f);
		proxActive = 1'b1;
		repeat (3) @(posedge refClk);
		#10;
		chk("level", 16'h001f, {4'h0, emitLvl});
		chk("sink", 16'h0003, {13'h0, emitSink});
		rdChk(8'h10, 8'h00);
		host.wr(DEV, 8'h10, 1, 16'h007a);
		rdChk(8'h10, 8'h0a);
		chk("level", 16'h0a1f, {4'h0, emitLvl});
		chk("sink", 16'h0007, {13'h0, emitSink});
		host.wr(7'h42, 8'h0f, 1, 16'h0000);
		rdChk(8'h0f, 8'h1f);
		rdChk(8'h20, 8'h00);
		host.wr(OLD, 8'h0b, 2, 16'h5532);
		host.wr(OLD, 8'h0d, 2, 16'h4566);
		chk("old lower", 16'h0009, lowLim2);
		chk("old upper", 16'h0015, upLim2);
		rdDevChk(OLD, 8'h0b, 8'h32);
		rdDevChk(OLD, 8'h0c, 8'h00);
		rdDevChk(OLD, 8'h0d, 8'h00);
		rdDevChk(OLD, 8'h0e, 8'h45);
		host.wr(OLD, 8'h0f, 2, 16'h0003);
		chk("old level", 16'h0003, {4'h0, emitLvl2});
		chk("old sink", 16'h0001, {13'h0, emitSink2});
		chk("nacks", 16'd3, 16'(host.nackCnt));
		@(posedge refClk);
		#10 rst = 1;
		repeat (2) @(posedge refClk);
		#10 rst = 0;
		repeat (2) @(posedge refClk);
		rdChk(8'h0f, 8'h00);
		chk("level", 16'h0000, {4'h0, emitLvl});
		chk("old upper", 16'h0000, upLim2);
		printVerdict();
	end
endmodule

// ---- bench/lwd_host.sv ----
module lwd_host (
	input  logic ref_clk,
	input  logic sdaLine,
	output logic sclDrive,
	output logic sdaDrive
);
	timeunit 1ns;
	timeprecision 1ns;
	int nackCnt = 0;
	initial begin
		sclDrive = 1'b1;
		sdaDrive = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk);
		#10;
	endtask
	task automatic bit_io(input logic b, output logic r);
		wait_clk(1);
		sdaDrive = b;
		wait_clk(3);
		sclDrive = 1'b1;
		wait_clk(3);
		r = sdaLine;
		sclDrive = 1'b0;
	endtask
	task automatic start_cond();
		wait_clk(1);
		sdaDrive = 1'b1;
		wait_clk(3);
		sclDrive = 1'b1;
		wait_clk(3);
		sdaDrive = 1'b0;
		wait_clk(3);
		sclDrive = 1'b0;
	endtask
	task automatic stop_cond();
		wait_clk(1);
		sdaDrive = 1'b0;
		wait_clk(3);
		sclDrive = 1'b1;
		wait_clk(3);
		sdaDrive = 1'b1;
		wait_clk(3);
	endtask
	// ack slot always released: device acks writes, a released slot ends a read
	task automatic xfer(input logic [7:0] o, output logic [7:0] i, output logic a);
		for (int k = 7; k >= 0; k--) bit_io(o[k], i[k]);
		bit_io(1'b1, a);
	endtask
	task automatic send(input logic [7:0] o);
		logic [7:0] i;
		logic       a;
		xfer(o, i, a);
		if (a !== 1'b0) nackCnt++;
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input int n,
		input logic [15:0] d);
		start_cond();
		send({dev, 1'b0});
		send(ptr);
		for (int k = 0; k < n; k++) send(d[8*k +: 8]);
		stop_cond();
	endtask
	task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d);
		logic a;
		start_cond();
		send({dev, 1'b0});
		send(ptr);
		start_cond();
		send({dev, 1'b1});
		xfer(8'hff, d, a);
		stop_cond();
	endtask
endmodule

// ---- bench/lwd_regs_chk.sv ----
module lwd_regs_chk (
	input logic        ref_clk,
	input logic        rst,
	input logic        sclIn,
	input logic        sdaOe,
	input logic        resultValid,
	input logic        useInfrared,
	input logic [15:0] visibleResult,
	input logic [15:0] infraredResult,
	input logic        proxActive,
	input logic [15:0] ambientLowerLimit,
	input logic [15:0] ambientUpperLimit,
	input logic        windowEvent,
	input logic [15:0] lastResult,
	input logic [11:0] emitterLevel,
	input logic [2:0]  emitterSink
);
	timeunit 1ns;
	timeprecision 1ns;
	wire [15:0] selRes = useInfrared ? infraredResult : visibleResult;
	wire outside = (selRes < ambientLowerLimit) || (selRes > ambientUpperLimit);
	wire [2:0] lvlZero = {emitterLevel[11:8] == 4'h0, emitterLevel[7:4] == 4'h0,
		emitterLevel[3:0] == 4'h0};
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_steady;
		proxActive ##1 proxActive && $stable(emitterLevel) ##1 $stable(emitterLevel);
	endsequence
	a_window_out: assert property (resultValid && outside |=> windowEvent)
		else $error("window event missing");
	a_window_in: assert property (resultValid && !outside |=> !windowEvent)
		else $error("window event inside window");
	a_event_cause: assert property (windowEvent |-> $past(resultValid))
		else $error("window event without result");
	a_last_capture: assert property (resultValid |=> lastResult == $past(selRes))
		else $error("wrong result captured");
	a_sink_idle: assert property (!proxActive |=> emitterSink == 3'b000)
		else $error("emitter sinks outside measurement");
	// sink and level are registered on the same edge
	a_sink_off: assert property ((emitterSink & lvlZero) == 3'b000)
		else $error("emitter sinks at level zero");
	a_sink_on: assert property (s_steady |-> emitterSink == ~lvlZero)
		else $error("emitter sink does not follow level");
	a_limit_update: assert property ($changed({ambientLowerLimit, ambientUpperLimit})
		|-> !sclIn)
		else $error("limit changed while bus clock high");
	a_sda_turn: assert property ($changed(sdaOe) |-> !sclIn)
		else $error("data drive changed while bus clock high");
endmodule

bind lwd_regs lwd_regs_chk chk (.ref_clk(ref_clk), .rst(rst), .sclIn(sclIn), .sdaOe(sdaOe),
	.resultValid(resultValid), .useInfrared(useInfrared), .visibleResult(visibleResult),
	.infraredResult(infraredResult), .proxActive(proxActive),
	.ambientLowerLimit(ambientLowerLimit), .ambientUpperLimit(ambientUpperLimit),
	.windowEvent(windowEvent), .lastResult(lastResult), .emitterLevel(emitterLevel),
	.emitterSink(emitterSink));

// ---- src/lwd_map.vh ----
// Function
// R01 - lower limit high byte at 0x0C
// R02 - upper limit bytes at 0x0D, 0x0E
// R03 - limits form window on visible or infrared
// R04 - host pauses ambient measurements before limit change
// R05 - revisions up to A10 use compressed limits
// R06 - 0x0D exists only from sequencer A03
// R07 - 0x0F bits 7:4 set emitter two
// R08 - single-emitter parts keep emitter two zero
// R09 - 0x0F bits 3:0 set emitter one
// R10 - 0000 off, 0001 least, 1111 most
// R11 - 0x10 bits 3:0 emitter three, rest reserved
// R12 - one/two emitter parts keep emitter three zero
// R13 - all limit and drive registers reset zero
// R14 - lower limit low byte at 0x0B
// R15 - compare each ambient result, flag window event
`ifndef LWD_MAP_VH
`define LWD_MAP_VH

`define LWD_OFS_LOWER_LO    8'h0b
`define LWD_OFS_LOWER_HI    8'h0c
`define LWD_OFS_UPPER_LO    8'h0d
`define LWD_OFS_UPPER_HI    8'h0e
`define LWD_OFS_DRIVE_12    8'h0f
`define LWD_OFS_DRIVE_3     8'h10

`define LWD_RST_BYTE        8'h00
`define LWD_RST_NIBBLE      4'h0
`define LWD_UNMAPPED_READ   8'h00

`define LWD_EMIT1_LSB       0
`define LWD_EMIT2_LSB       4
`define LWD_EMIT3_LSB       0
`define LWD_FIELD_W         4
`define LWD_LEVEL_OFF       4'h0

`define LWD_REV_A03         8'h03
`define LWD_REV_A10         8'h10

`define LWD_CMP_EXP_MSB     7
`define LWD_CMP_EXP_LSB     4
`define LWD_CMP_FRAC_SHIFT  4

`define LWD_BIT_LAST        4'd7
`define LWD_ACK_SLOT        4'd8
`define LWD_BIT_PRE         4'd15

`endif

// ---- src/lwd_regs.v ----
`include "lwd_map.vh"

module lwd_regs #(
	parameter [6:0] DEV_ADDR  = 7'h40,
	parameter [7:0] SEQ_REV   = 8'h11,
	parameter       EMITTERS  = 3
) (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        sclIn,
	input  wire        sdaIn,
	output wire        sdaOut,
	output wire        sdaOe,
	input  wire        resultValid,
	input  wire        useInfrared,
	input  wire [15:0] visibleResult,
	input  wire [15:0] infraredResult,
	input  wire        proxActive,
	output wire [15:0] ambientLowerLimit,
	output wire [15:0] ambientUpperLimit,
	output wire        windowEvent,
	output wire [15:0] lastResult,
	output wire [11:0] emitterLevel,
	output wire [2:0]  emitterSink
);

	localparam COMPRESSED  = (SEQ_REV <= `LWD_REV_A10);
	localparam UPPER_LO_OK = (SEQ_REV >= `LWD_REV_A03);

	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_ADDR = 3'd1;
	localparam [2:0] ST_REG  = 3'd2;
	localparam [2:0] ST_WR   = 3'd3;
	localparam [2:0] ST_RD   = 3'd4;

	// compressed limit: upper nibble exponent, lower nibble fraction
	function [15:0] lwd_expand;
		input [7:0] c;
		reg   [31:0] w;
		begin
			w = {27'd0, 1'b1, c[3:0]} << c[`LWD_CMP_EXP_MSB:`LWD_CMP_EXP_LSB];
			w = w >> `LWD_CMP_FRAC_SHIFT;
			if (c == `LWD_RST_BYTE) begin
				lwd_expand = 16'h0000;
			end else if (|w[31:16]) begin
				lwd_expand = 16'hffff;
			end else begin
				lwd_expand = w[15:0];
			end
		end
	endfunction

	// a register that the revision leaves out reads zero and drops writes
	function hit;
		input [7:0] a;
		begin
			case (a)
				`LWD_OFS_LOWER_LO: hit = 1'b1; // R14
				`LWD_OFS_LOWER_HI: hit = !COMPRESSED; // R01 R05
				`LWD_OFS_UPPER_LO: hit = UPPER_LO_OK && !COMPRESSED; // R06 R05
				`LWD_OFS_UPPER_HI: hit = 1'b1; // R02
				`LWD_OFS_DRIVE_12: hit = 1'b1;
				`LWD_OFS_DRIVE_3:  hit = 1'b1;
				default:           hit = 1'b0;
			endcase
		end
	endfunction

	reg  [7:0] lowerLo_q;
	reg  [7:0] lowerHi_q;
	reg  [7:0] upperLo_q;
	reg  [7:0] upperHi_q;
	reg  [7:0] drive12_q;
	reg  [3:0] drive3_q;

	reg  [2:0] state_q;
	reg  [3:0] bitCnt_q;
	reg  [7:0] rxShift_q;
	reg  [7:0] txShift_q;
	reg  [7:0] ptr_q;
	reg        readDir_q;
	reg        masterNack_q;
	reg        sdaOut_q;
	reg        sdaOe_q;
	reg        sclPrev_q;
	reg        sdaPrev_q;

	reg  [7:0] readData;
	reg        regWrite;

	wire sclRise   = sclIn & ~sclPrev_q;
	wire sclFall   = ~sclIn & sclPrev_q;
	wire startCond = sclIn & sclPrev_q & sdaPrev_q & ~sdaIn;
	wire stopCond  = sclIn & sclPrev_q & ~sdaPrev_q & sdaIn;

	assign sdaOut = sdaOut_q;
	assign sdaOe  = sdaOe_q;

	always @* begin
		readData = `LWD_UNMAPPED_READ;
		if (hit(ptr_q)) begin
			case (ptr_q)
				`LWD_OFS_LOWER_LO: readData = lowerLo_q; // R14
				`LWD_OFS_LOWER_HI: readData = lowerHi_q; // R01
				`LWD_OFS_UPPER_LO: readData = upperLo_q; // R02
				`LWD_OFS_UPPER_HI: readData = upperHi_q; // R02
				`LWD_OFS_DRIVE_12: readData = drive12_q;
				`LWD_OFS_DRIVE_3:  readData = {`LWD_RST_NIBBLE, drive3_q}; // R11
				default:           readData = `LWD_UNMAPPED_READ;
			endcase
		end
	end

	// byte taken on the falling clock edge that closes its eighth bit
	always @* begin
		regWrite = sclFall && (state_q == ST_WR) && (bitCnt_q == `LWD_BIT_LAST);
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclPrev_q <= sclIn;
			sdaPrev_q <= sdaIn;
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			state_q      <= ST_IDLE;
			bitCnt_q     <= 4'd0;
			rxShift_q    <= 8'h00;
			txShift_q    <= 8'h00;
			ptr_q        <= 8'h00;
			readDir_q    <= 1'b0;
			masterNack_q <= 1'b0;
			sdaOut_q     <= 1'b1;
			sdaOe_q      <= 1'b0;
		end else if (startCond) begin
			state_q  <= ST_ADDR;
			bitCnt_q <= `LWD_BIT_PRE;
			sdaOe_q  <= 1'b0;
		end else if (stopCond) begin
			state_q  <= ST_IDLE;
			sdaOe_q  <= 1'b0;
		end else if (state_q != ST_IDLE) begin
			if (sclRise) begin
				if (bitCnt_q == `LWD_ACK_SLOT) begin
					masterNack_q <= sdaIn;
				end else begin
					rxShift_q <= {rxShift_q[6:0], sdaIn};
				end
			end else if (sclFall) begin
				// the fall that closes a start carries no bit
				if (bitCnt_q == `LWD_BIT_PRE) begin
					bitCnt_q <= 4'd0;
				end else if (bitCnt_q < `LWD_BIT_LAST) begin
					bitCnt_q <= bitCnt_q + 4'd1;
					if (state_q == ST_RD) begin
						sdaOut_q  <= txShift_q[6];
						sdaOe_q   <= 1'b1;
						txShift_q <= {txShift_q[6:0], 1'b0};
					end
				end else if (bitCnt_q == `LWD_BIT_LAST) begin
					bitCnt_q <= `LWD_ACK_SLOT;
					case (state_q)
						ST_ADDR: begin
							if (rxShift_q[7:1] == DEV_ADDR) begin
								readDir_q <= rxShift_q[0];
								sdaOut_q  <= 1'b0;
								sdaOe_q   <= 1'b1;
							end else begin
								state_q <= ST_IDLE;
								sdaOe_q <= 1'b0;
							end
						end
						ST_REG: begin
							ptr_q    <= rxShift_q;
							sdaOut_q <= 1'b0;
							sdaOe_q  <= 1'b1;
						end
						ST_WR: begin
							// pointer advances so bytes of a limit go in one burst
							ptr_q    <= ptr_q + 8'h01;
							sdaOut_q <= 1'b0;
							sdaOe_q  <= 1'b1;
						end
						ST_RD: begin
							sdaOe_q <= 1'b0;
						end
						default: begin
							state_q <= ST_IDLE;
							sdaOe_q <= 1'b0;
						end
					endcase
				end else begin
					bitCnt_q <= 4'd0;
					sdaOe_q  <= 1'b0;
					case (state_q)
						ST_ADDR: begin
							if (readDir_q) begin
								state_q   <= ST_RD;
								txShift_q <= readData;
								sdaOut_q  <= readData[7];
								sdaOe_q   <= 1'b1;
								ptr_q     <= ptr_q + 8'h01;
							end else begin
								state_q <= ST_REG;
							end
						end
						ST_REG: begin
							state_q <= ST_WR;
						end
						ST_WR: begin
							state_q <= ST_WR;
						end
						ST_RD: begin
							if (masterNack_q) begin
								state_q <= ST_IDLE;
							end else begin
								txShift_q <= readData;
								sdaOut_q  <= readData[7];
								sdaOe_q   <= 1'b1;
								ptr_q     <= ptr_q + 8'h01;
							end
						end
						default: begin
							state_q <= ST_IDLE;
						end
					endcase
				end
			end
		end
	end

	// host is expected to pause ambient work first; a torn pair is possible otherwise
	always @(posedge ref_clk) begin
		if (rst) begin
			lowerLo_q <= `LWD_RST_BYTE; // R13
			lowerHi_q <= `LWD_RST_BYTE; // R13
			upperLo_q <= `LWD_RST_BYTE; // R13
			upperHi_q <= `LWD_RST_BYTE; // R13
			drive12_q <= `LWD_RST_BYTE; // R13
			drive3_q  <= `LWD_RST_NIBBLE; // R13
		end else if (regWrite && hit(ptr_q)) begin
			case (ptr_q)
				`LWD_OFS_LOWER_LO: lowerLo_q <= rxShift_q; // R14
				`LWD_OFS_LOWER_HI: lowerHi_q <= rxShift_q; // R01
				`LWD_OFS_UPPER_LO: upperLo_q <= rxShift_q; // R02 R06
				`LWD_OFS_UPPER_HI: upperHi_q <= rxShift_q; // R02
				`LWD_OFS_DRIVE_12: drive12_q <= rxShift_q; // R07 R09
				`LWD_OFS_DRIVE_3:  drive3_q  <= rxShift_q[3:0]; // R11
				default:           drive3_q  <= drive3_q;
			endcase
		end
	end

	// older revisions keep one compressed byte per limit
	assign ambientLowerLimit = COMPRESSED ? lwd_expand(lowerLo_q) :
		{lowerHi_q, lowerLo_q}; // R05 R01 R14
	assign ambientUpperLimit = COMPRESSED ? lwd_expand(upperHi_q) :
		{upperHi_q, UPPER_LO_OK ? upperLo_q : 8'h00}; // R05 R02 R06

	lwd_window_cmp u_window (
		.ref_clk        (ref_clk),
		.rst            (rst),
		.resultValid    (resultValid),
		.useInfrared    (useInfrared),
		.visibleResult  (visibleResult),
		.infraredResult (infraredResult),
		.lowerLimit     (ambientLowerLimit),
		.upperLimit     (ambientUpperLimit),
		.windowEvent_q  (windowEvent),
		.lastResult_q   (lastResult)
	);

	wire [11:0] fields = {drive3_q[`LWD_EMIT3_LSB +: `LWD_FIELD_W],
		drive12_q[`LWD_EMIT2_LSB +: `LWD_FIELD_W],
		drive12_q[`LWD_EMIT1_LSB +: `LWD_FIELD_W]}; // R07 R09 R11

	reg  [11:0] level_q;
	reg  [2:0]  sink_q;
	wire [11:0] level_d;
	wire [2:0]  sink_d;

	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_emit
			// absent pins are forced off even if the host writes a level
			assign level_d[4*i +: 4] = (i < EMITTERS) ? fields[4*i +: 4] : `LWD_LEVEL_OFF; // R08 R12
			assign sink_d[i] = proxActive && (level_d[4*i +: 4] != `LWD_LEVEL_OFF); // R10
		end
	endgenerate

	always @(posedge ref_clk) begin
		if (rst) begin
			level_q <= {3{`LWD_LEVEL_OFF}};
			sink_q  <= 3'h0;
		end else begin
			level_q <= level_d;
			sink_q  <= sink_d;
		end
	end

	assign emitterLevel = level_q; // R10
	assign emitterSink  = sink_q;

endmodule

// ---- src/lwd_window_cmp.v ----
`include "lwd_map.vh"

module lwd_window_cmp (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        resultValid,
	input  wire        useInfrared,
	input  wire [15:0] visibleResult,
	input  wire [15:0] infraredResult,
	input  wire [15:0] lowerLimit,
	input  wire [15:0] upperLimit,
	output reg         windowEvent_q,
	output reg  [15:0] lastResult_q
);

	reg  [15:0] selected;
	reg         outside;

	// the event is flagged for every valid reading that lies outside the window
	always @* begin
		selected = useInfrared ? infraredResult : visibleResult; // R03
		outside  = (selected < lowerLimit) || (selected > upperLimit); // R03
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			windowEvent_q <= 1'b0;
			lastResult_q  <= 16'h0000;
		end else begin
			windowEvent_q <= resultValid & outside; // R15
			if (resultValid) begin
				lastResult_q <= selected;
			end
		end
	end

endmodule
